// ### sroc_pkg.sv
package sroc_pkg;

  // ----------------------------------------------------------------
  // geometry and register map
  // ----------------------------------------------------------------
  localparam int          SROC_NUM_OUT   = 7;
  localparam int          SROC_AW        = 4;
  localparam int          SROC_DW        = 16;
  // one config word per output at index 0..6, a status word at 8
  localparam logic [3:0]  SROC_OFS_OUT0  = 4'h0;
  localparam logic [3:0]  SROC_OFS_STAT  = 4'h8;

  // ----------------------------------------------------------------
  // field positions inside a config word
  // ----------------------------------------------------------------
  localparam int SROC_POS_COARSE = 0;   // [2:0]
  localparam int SROC_POS_FINE   = 3;   // [5:3]
  localparam int SROC_POS_BIAS   = 6;
  localparam int SROC_POS_AMP    = 7;   // [8:7]
  localparam int SROC_POS_FMT    = 9;
  localparam int SROC_POS_EN     = 10;
  localparam int SROC_POS_PD     = 11;
  localparam int SROC_POS_SRC    = 12;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SROC_RST_COARSE = 3'h0;
  localparam logic [2:0] SROC_RST_FINE   = 3'h0;
  localparam logic       SROC_RST_BIAS   = 1'h0;
  localparam logic [1:0] SROC_RST_AMP    = 2'h0;
  localparam logic       SROC_RST_FMT    = 1'h0;
  localparam logic       SROC_RST_EN     = 1'h0;
  localparam logic       SROC_RST_PD     = 1'h0;
  localparam logic       SROC_RST_SRC    = 1'h1;

  // ----------------------------------------------------------------
  // delay and swing figures
  // ----------------------------------------------------------------
  localparam int SROC_COARSE_STEP_PS = 255;
  localparam logic [7:0] SROC_FINE_PS_0 = 8'h00;   // 0 ps
  localparam logic [7:0] SROC_FINE_PS_1 = 8'h19;   // 25 ps
  localparam logic [7:0] SROC_FINE_PS_2 = 8'h32;   // 50 ps
  localparam logic [7:0] SROC_FINE_PS_3 = 8'h4B;   // 75 ps
  localparam logic [7:0] SROC_FINE_PS_4 = 8'h55;   // 85 ps
  localparam logic [7:0] SROC_FINE_PS_5 = 8'h6E;   // 110 ps
  localparam logic [7:0] SROC_FINE_PS_6 = 8'h87;   // 135 ps
  localparam logic [7:0] SROC_FINE_PS_7 = 8'hA0;   // 160 ps
  localparam int SROC_AMP_STEP_MV = 250;

  typedef enum logic [1:0] {
    SROC_MODE_OFF,
    SROC_MODE_LOW,
    SROC_MODE_LVDS,
    SROC_MODE_LVPECL
  } sroc_mode_t;

  // one output's settings as held in flops
  typedef struct packed {
    logic       src;
    logic       pd;
    logic       en;
    logic       fmt;
    logic [1:0] amp;
    logic       bias;
    logic [2:0] fine;
    logic [2:0] coarse;
  } sroc_cfg_t;

  // what the analog slice of one output is told to do
  typedef struct packed {
    sroc_mode_t  mode;
    logic        src_sysref;
    logic        bias_on;
    logic [10:0] delay_ps;
    logic [10:0] swing_mv;
  } sroc_drive_t;

  localparam sroc_cfg_t SROC_CFG_RST = '{
    src:    SROC_RST_SRC,
    pd:     SROC_RST_PD,
    en:     SROC_RST_EN,
    fmt:    SROC_RST_FMT,
    amp:    SROC_RST_AMP,
    bias:   SROC_RST_BIAS,
    fine:   SROC_RST_FINE,
    coarse: SROC_RST_COARSE
  };

endpackage

// ### sroc_decode.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// per-output decode of stored settings into drive controls
// ----------------------------------------------------------------
module sroc_decode
  import sroc_pkg::*;
(
  input  sroc_pkg::sroc_cfg_t   cfg,  // stored settings
  output sroc_pkg::sroc_drive_t drv   // decoded controls
);

  // fine steps are not uniform, so a table not a multiply
  function automatic logic [7:0] fine_ps(input logic [2:0] code);
    case (code)
      3'h0:    fine_ps = SROC_FINE_PS_0;
      3'h1:    fine_ps = SROC_FINE_PS_1;
      3'h2:    fine_ps = SROC_FINE_PS_2;
      3'h3:    fine_ps = SROC_FINE_PS_3;
      3'h4:    fine_ps = SROC_FINE_PS_4;
      3'h5:    fine_ps = SROC_FINE_PS_5;
      3'h6:    fine_ps = SROC_FINE_PS_6;
      default: fine_ps = SROC_FINE_PS_7;
    endcase
  endfunction

  wire [10:0] coarse_ps;
  wire [10:0] total_ps;
  wire [10:0] swing;

  // delay and swing arithmetic
  assign coarse_ps = 11'(cfg.coarse * SROC_COARSE_STEP_PS);   // see (RQ1)
  assign total_ps  = coarse_ps + {3'h0, fine_ps(cfg.fine)};  // see (RQ2) (RQ3)
  assign swing     = 11'((cfg.amp + 1) * SROC_AMP_STEP_MV);  // see (RQ5)

  // power-down masks format, enable and amplitude
  assign drv.mode = cfg.pd  ? SROC_MODE_OFF :                // see (RQ6)
                    !cfg.en ? SROC_MODE_LOW :                // see (RQ8)
                    cfg.fmt ? SROC_MODE_LVPECL :             // see (RQ7)
                              SROC_MODE_LVDS;
  assign drv.src_sysref = cfg.src;                           // see (RQ9)
  assign drv.bias_on    = cfg.bias & ~cfg.pd;                // see (RQ4)
  assign drv.delay_ps   = total_ps;
  // swing only meaningful for lvds, zero otherwise
  assign drv.swing_mv   = (drv.mode == SROC_MODE_LVDS) ? swing : 11'h000;

endmodule

// ### sroc_bank.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// (RQ1) coarse delay is code times 255 ps
// (RQ2) fine delay codes map to table ps
// (RQ3) fine delay adds onto coarse delay
// (RQ4) bias bit biases output to lvds crossing
// (RQ5) lvds amplitude codes give 250..1000 mV
// (RQ6) power-down overrides format, enable, amplitude
// (RQ7) format bit picks lvds or lvpecl
// (RQ8) disabled output held static low
// (RQ9) source bit picks clock or sysref
// (RQ10) each output holds own readable fields
module sroc_bank
  import sroc_pkg::*;
#(
  parameter int NUM_OUT = SROC_NUM_OUT   // reference outputs
)(
  input  wire logic                 clk_sys,  // 40 MHz system clock
  input  wire logic                 nrst,     // sync reset, active low
  input  wire logic [SROC_AW-1:0]   addr,     // register index
  input  wire logic [SROC_DW-1:0]   wdata,    // write data
  input  wire logic                 wr,       // write strobe
  input  wire logic                 rd,       // read strobe
  output logic      [SROC_DW-1:0]   rdata,    // read data, next cycle
  output sroc_pkg::sroc_drive_t     drive [NUM_OUT]  // per-output controls
);
  import sroc_pkg::*;

  // index map has room for eight outputs below the status word
  if (NUM_OUT < 1 || NUM_OUT > 8) begin : g_bad_num_out
    $error("NUM_OUT must be 1..8 to fit the index map");
  end

  // ----------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------
  localparam logic [SROC_DW-1:0] FIELD_MASK = 16'h1FFF;

  function automatic logic [SROC_AW-1:0] addr_of(input int i);
    return SROC_AW'(i) + SROC_OFS_OUT0;
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  sroc_cfg_t cfg_q [NUM_OUT];
  logic [SROC_DW-1:0] rdata_q;
  logic [SROC_DW-1:0] rdata_d;

  function automatic sroc_cfg_t unpack_word(input logic [SROC_DW-1:0] w);
    sroc_cfg_t c;
    c.coarse = w[SROC_POS_COARSE +: 3];
    c.fine   = w[SROC_POS_FINE +: 3];
    c.bias   = w[SROC_POS_BIAS];
    c.amp    = w[SROC_POS_AMP +: 2];
    c.fmt    = w[SROC_POS_FMT];
    c.en     = w[SROC_POS_EN];
    c.pd     = w[SROC_POS_PD];
    c.src    = w[SROC_POS_SRC];
    return c;
  endfunction

  function automatic logic [SROC_DW-1:0] pack_word(input sroc_cfg_t c);
    logic [SROC_DW-1:0] w;
    w = '0;
    w[SROC_POS_COARSE +: 3] = c.coarse;
    w[SROC_POS_FINE +: 3]   = c.fine;
    w[SROC_POS_BIAS]        = c.bias;
    w[SROC_POS_AMP +: 2]    = c.amp;
    w[SROC_POS_FMT]         = c.fmt;
    w[SROC_POS_EN]          = c.en;
    w[SROC_POS_PD]          = c.pd;
    w[SROC_POS_SRC]         = c.src;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire        hit_out  = ({1'b0, addr} - {1'b0, SROC_OFS_OUT0})
                         < (SROC_AW+1)'(NUM_OUT);
  wire [2:0]  out_idx  = 3'(addr - SROC_OFS_OUT0);
  wire        hit_stat = (addr == SROC_OFS_STAT);
  logic [SROC_DW-1:0] stat_word;

  // status: which outputs are live (not off, not held low)
  always_comb begin
    stat_word = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      stat_word[i] = (drive[i].mode == SROC_MODE_LVDS) ||
                     (drive[i].mode == SROC_MODE_LVPECL);
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rdata_d = '0;
    if (hit_out)
      rdata_d = pack_word(cfg_q[out_idx]);      // see (RQ10)
    else if (hit_stat)
      rdata_d = stat_word;
  end

  // ----------------------------------------------------------------
  // per-output field registers and decode
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    wire we = wr && hit_out && (out_idx == 3'(g));

    // each output owns a full set of fields
    always_ff @(posedge clk_sys) begin
      if (!nrst)
        cfg_q[g] <= SROC_CFG_RST;                // see (RQ10)
      else if (we)
        cfg_q[g] <= unpack_word(wdata);          // see (RQ10)
    end

    sroc_decode u_dec (
      .cfg (cfg_q[g]),
      .drv (drive[g])
    );

    // written word reads back one strobe later
    a_cfg_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
      we ##1 (rd && addr == addr_of(g)) |=>
        rdata == ($past(wdata, 2) & FIELD_MASK))
      else $error("config readback mismatch");   // see (RQ10)

    a_pd_forces_off: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_q[g].pd |-> drive[g].mode == SROC_MODE_OFF
        && drive[g].swing_mv == 11'h000)
      else $error("power-down not obeyed");      // see (RQ6)

    a_disable_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      !cfg_q[g].pd && !cfg_q[g].en |-> drive[g].mode == SROC_MODE_LOW)
      else $error("disabled output not low");    // see (RQ8)

    a_fmt_select: assert property (@(posedge clk_sys) disable iff (!nrst)
      !cfg_q[g].pd && cfg_q[g].en |-> drive[g].mode ==
        (cfg_q[g].fmt ? SROC_MODE_LVPECL : SROC_MODE_LVDS))
      else $error("format select wrong");        // see (RQ7)

    a_coarse_only: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_q[g].fine == 3'h0 |->
        drive[g].delay_ps == 11'(cfg_q[g].coarse * 255))
      else $error("coarse delay wrong");         // see (RQ1)

    a_fine_table: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_q[g].coarse == 3'h0 && cfg_q[g].fine == 3'h4 |->
        drive[g].delay_ps == 11'd85)
      else $error("fine delay table wrong");     // see (RQ2)

    a_delay_sum: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_q[g].coarse == 3'h7 && cfg_q[g].fine == 3'h7 |->
        drive[g].delay_ps == 11'd1945)
      else $error("delay sum wrong");            // see (RQ3)

    a_lvds_swing: assert property (@(posedge clk_sys) disable iff (!nrst)
      drive[g].mode == SROC_MODE_LVDS |->
        drive[g].swing_mv == 11'(250 * (cfg_q[g].amp + 1)))
      else $error("lvds swing wrong");           // see (RQ5)

    a_bias_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
      !cfg_q[g].pd |-> drive[g].bias_on == cfg_q[g].bias)
      else $error("bias does not follow bit");   // see (RQ4)

    a_src_select: assert property (@(posedge clk_sys) disable iff (!nrst)
      $changed(cfg_q[g].src) |-> drive[g].src_sysref == cfg_q[g].src)
      else $error("source select wrong");        // see (RQ9)

    a_reset_vals: assert property (@(posedge clk_sys)
      $past(!nrst) |-> drive[g].src_sysref && !drive[g].bias_on
        && drive[g].mode == SROC_MODE_LOW
        && drive[g].delay_ps == 11'h000)
      else $error("reset defaults wrong");       // see (RQ9)
  end

  // read data register, held only in the cycle after a read
  always_ff @(posedge clk_sys) begin
    if (!nrst)
      rdata_q <= '0;
    else if (rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= '0;
  end

  assign rdata = rdata_q;

  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rd |=> rdata == '0) else $error("read data without read");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && !hit_out && !hit_stat |=> rdata == '0)
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // coverage of main scenarios
  // ----------------------------------------------------------------
  c_lvpecl_on: cover property (@(posedge clk_sys) disable iff (!nrst)
    drive[0].mode == SROC_MODE_LVPECL);
  c_lvds_max: cover property (@(posedge clk_sys) disable iff (!nrst)
    drive[0].swing_mv == 11'd1000);
  c_pd_write: cover property (@(posedge clk_sys) disable iff (!nrst)
    wr && hit_out && wdata[SROC_POS_PD]);
  c_max_delay: cover property (@(posedge clk_sys) disable iff (!nrst)
    drive[NUM_OUT-1].delay_ps == 11'd1945);

endmodule

// ### test_sysref_output_state_config.sv
`timescale 1ns/1ps
module test_sysref_output_state_config;
  import sroc_pkg::*;

  // ----------------------------------------------------------------
  // stimulus, design and reference model
  // ----------------------------------------------------------------
  logic                 clk_sys;
  logic                 nrst;
  logic [SROC_AW-1:0]   addr;
  logic [SROC_DW-1:0]   wdata;
  logic                 wr;
  logic                 rd;
  logic [SROC_DW-1:0]   rdata;
  sroc_drive_t          drive [SROC_NUM_OUT];
  int                   n_fail;
  int                   n_compared;
  int                   mdl [7];
  int                   fps [8] = '{0, 25, 50, 75, 85, 110, 135, 160};
  logic [15:0]          words [5] = '{16'h1FFF, 16'h0780, 16'h0180,
                                      16'h05C0, 16'hFFFF};

  sroc_bank #(.NUM_OUT(SROC_NUM_OUT)) u_dut (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .addr    (addr),
    .wdata   (wdata),
    .wr      (wr),
    .rd      (rd),
    .rdata   (rdata),
    .drive   (drive)
  );

  // free-running 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // model helpers and checks
  // ----------------------------------------------------------------
  // 0 off, 1 static low, 2 lvds, 3 lvpecl; power-down wins over all
  function automatic int exp_mode(int w);
    if ((w >> 11) & 1) return 0;
    if (((w >> 10) & 1) == 0) return 1;
    return ((w >> 9) & 1) ? 3 : 2;
  endfunction

  // status word lists outputs that actually toggle
  function automatic int exp_rd(int a);
    int s;
    s = 0;
    if (a < 7) return mdl[a];
    if (a != 8) return 0;
    for (int i = 0; i < 7; i++) if (exp_mode(mdl[i]) >= 2) s |= 1 << i;
    return s;
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus tasks: strobes change just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
    if (a < 7) mdl[a] = d & 16'h1FFF;
  endtask

  // read data stand one cycle only, so look twice
  task automatic rd_reg(logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    chk("rdata", exp_rd(a), rdata);
    @(posedge clk_sys);
    #1;
    chk("rdata_idle", 0, rdata);
  endtask

  // every output compared against the model after each change, except the back-to-back writes
  task automatic check_drv();
    int w;
    int m;
    #1;
    for (int i = 0; i < 7; i++) begin
      w = mdl[i];
      m = exp_mode(w);
      chk("mode", m, drive[i].mode);
      chk("src", (w >> 12) & 1, drive[i].src_sysref);
      chk("bias", (m == 0) ? 0 : (w >> 6) & 1, drive[i].bias_on);
      chk("delay", (w & 7) * 255 + fps[(w >> 3) & 7],
          drive[i].delay_ps);
      chk("swing", (m == 2) ? (((w >> 7) & 3) + 1) * 250 : 0,
          drive[i].swing_mv);
    end
  endtask

  // ----------------------------------------------------------------
  // watchdog: the whole run needs well under 3000 cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_compared = 0;
    nrst = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    void'($urandom(32'hA578161E));
    for (int i = 0; i < 7; i++) mdl[i] = 16'h1000;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    // defaults, then every index including unmapped ones
    check_drv();
    for (int a = 0; a < 16; a++) rd_reg(a[3:0]);
    // each delay and amplitude code on a rotating output
    for (int c = 0; c < 8; c++) begin
      wr_reg(c % 7, 16'h0440 | c | (c << 3) | ((c & 3) << 7)
             | ((c & 1) << 12));
      check_drv();
    end
    // power-down overriding format, enable and amplitude
    foreach (words[k]) begin
      wr_reg(3, words[k]);
      check_drv();
      rd_reg(3);
    end
    // status word is read-only
    wr_reg(8, 16'hFFFF);
    rd_reg(8);
    // random words on random indices, read back at random
    repeat (60) begin
      wr_reg($urandom_range(0, 15), $urandom);
      check_drv();
      rd_reg($urandom_range(0, 15));
    end
    // back-to-back writes and reads, then a reset in mid-run
    for (int i = 0; i < 7; i++) wr_reg(i, $urandom);
    for (int i = 0; i < 7; i++) rd_reg(i);
    @(posedge clk_sys);
    nrst <= 1'b0;
    @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) mdl[i] = 16'h1000;
    check_drv();
    rd_reg(8);
    tally_and_finish();
  end
endmodule
